//--- include/adc_seq_pkg.sv
/*
  Shared constants and types for the converter sequencer: the serial control
  word layout, sequencer states, register offsets and reset values.
  Assumes a 50 MHz system clock and a serial host running a much slower clock.
*/
package adc_seq_pkg;

  // ----------------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CODE_BITS = 12;
  localparam logic [4:0] CTRL_LAST_EDGE = 5'h0b;  // 12th falling edge.
  localparam logic [4:0] WORD_LAST_EDGE = 5'h0f;  // 16th falling edge.
  localparam logic [4:0] SAR_FIRST_EDGE = 5'h02;  // Decides code bit 11.
  localparam logic [4:0] SAR_LAST_EDGE = 5'h0d;   // Decides code bit 0.
  localparam logic [4:0] TRACK_EDGE = 5'h0d;      // 14th edge returns to track.
  localparam logic [4:0] OUT_LAST_EDGE = 5'h0e;
  localparam int unsigned WRITE_POS = 11;
  localparam logic [11:0] SAR_START = 12'h800;

  // Control word without the write bit, first received field first.
  typedef struct packed {
    logic auto_cycle_select;
    logic [3:0] channel_addr;
    logic power_mode_bit_high;
    logic power_mode_bit_low;
    logic shadow;
    logic weak_tri;
    logic range;
    logic coding;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{default: 1'b0};

  // Sequencer states.
  typedef enum logic [3:0] {
    S_OFF = 4'b0001,
    S_ARM = 4'b0010,
    S_MASK_RUN = 4'b0100,
    S_CONSEC = 4'b1000
  } seq_state_t;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL_VIEW = 5'h00;
  localparam logic [4:0] OFF_MASK_VIEW = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_TEST_LEVEL = 5'h0c;
  localparam logic [4:0] OFF_TEST_CFG = 5'h10;
  localparam logic [11:0] TEST_LEVEL_RESET = 12'h000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [3:0] PTR_RESET = 4'h0;

endpackage

//--- hw/sync_stage.sv
/*
  Two flip-flop synchroniser for a group of asynchronous level inputs.
  Assumes the inputs are sampled far faster than they change.
*/
`timescale 1ns/10ps

module sync_stage #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

//--- hw/adc_channel_sequencer.sv
/*
  Digital control of a 16-channel 12-bit successive approximation converter:
  serial control port, channel sequencer, SAR stepping and result framing,
  plus an Avalon-MM slave for inspection and a digital test level.
  Assumes serial pins and the comparator come from outside the mclk domain.
*/
// Implementation choices: the register offsets and register access over Avalon-MM.
// Overview of operation
// - Serial clock edges step shifting and SAR.
// - Control bit 1 selects single or double span.
// - Control bit 0 selects binary or twos complement.
// - One code step is reference over 4096.
// - Double span twos complement centres on reference.
// - Result word: channel address then twelve code bits.
// - Unsequenced conversions use control channel address.
// - Mask load starts at lowest selected channel.
// - Each transfer advances to next selected channel.
// - After highest selected channel, wrap to first.
// - Writes with pair one-zero keep sequence running.
// - Any other pair written ends the sequence.
// - Pair one-one converts channel zero up to address.
// - Consecutive sequence restarts at channel zero.
// - Control loads from first twelve bits when write.
// - After pair zero-one, next word loads mask.
// - First mask bit is channel zero.
// - Conversion takes sixteen serial clocks.
`timescale 1ns/10ps

module adc_channel_sequencer (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic dout,
  output logic dout_oe_n,
  input wire logic cmp_in,
  output logic [11:0] dac_code,
  output logic [3:0] mux_sel,
  output logic span_double,
  output logic track_hold,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [3:0] pins_s;
  logic cs_n_s, sclk_s, din_s, cmp_s;
  logic cs_d, sclk_d;

  sync_stage #(.WIDTH(4)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({~cs_n, sclk, din, cmp_in}),  // Select enters inverted so reset reads as idle.
    .sync_out(pins_s)
  );

  assign {cs_n_s, sclk_s, din_s, cmp_s} = pins_s ^ 4'h8;  // No false select fall after reset.

  // Edges are seen in the cycle the second synchroniser stage changes, against a copy one mclk older.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cs_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end

  logic cs_fall, sclk_fall, end_xfer, active;
  logic [4:0] edge_cnt, next_edge_cnt;
  assign cs_fall = cs_d & ~cs_n_s;
  assign sclk_fall = sclk_d & ~sclk_s & ~cs_n_s & active;
  assign end_xfer = sclk_fall && edge_cnt == adc_seq_pkg::WORD_LAST_EDGE;

  // ----------------------------------------------------------------------
  // Sequencer helper
  // ----------------------------------------------------------------------
  // Next selected channel above 'from', wrapping; mask bit 15 is channel 0.
  function automatic logic [3:0] next_sel(input logic [15:0] m, input logic [3:0] from);
    logic [3:0] c;
    logic found;
    next_sel = from;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      c = 4'(int'(from) + i);
      if (!found && m[4'hf - c]) begin
        next_sel = c;
        found = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Serial transfer, SAR and sequencer state
  // ----------------------------------------------------------------------
  adc_seq_pkg::ctrl_t ctrl, next_ctrl;
  adc_seq_pkg::seq_state_t state, next_state;
  logic [15:0] mask, next_mask, rx, next_rx, last_word, next_last_word;
  logic [11:0] trial, next_trial, test_level;
  logic [3:0] ptr, next_ptr, conv_ch, next_conv_ch;
  logic next_active, wrote, next_wrote, next_dout, next_drive_n, next_hold, use_test, cmp_bit;
  logic [15:0] word;

  // The test level lets software exercise the SAR with no analog front end.
  assign cmp_bit = use_test ? (test_level >= trial) : cmp_s;
  // Twos complement flips the MSB, which puts the reference at zero code.
  assign word = {conv_ch, trial ^ {ctrl.coding, 11'h000}};

  always_comb begin
    next_ctrl = ctrl;
    next_state = state;
    next_mask = mask;
    next_rx = rx;
    next_trial = trial;
    next_ptr = ptr;
    next_conv_ch = conv_ch;
    next_edge_cnt = edge_cnt;
    next_active = active;
    next_wrote = wrote;
    next_dout = dout;
    next_hold = track_hold;
    next_last_word = last_word;
    next_drive_n = cs_n_s;
    if (cs_n_s) begin
      next_active = 1'b0;
    end
    if (cs_fall) begin
      // Sample and start; the channel comes from the pointer while sequencing.
      next_active = 1'b1;
      next_edge_cnt = 5'h00;
      next_wrote = 1'b0;
      next_trial = adc_seq_pkg::SAR_START;
      next_hold = 1'b1;
      if (state == adc_seq_pkg::S_MASK_RUN || state == adc_seq_pkg::S_CONSEC) begin
        next_conv_ch = ptr;
      end else begin
        next_conv_ch = ctrl.channel_addr;
      end
      next_dout = next_conv_ch[3];
    end else if (sclk_fall) begin
      next_rx = {rx[14:0], din_s};
      next_edge_cnt = edge_cnt + 5'h01;
      // Each SAR step is one serial clock; no other clock drives it.
      if (edge_cnt >= adc_seq_pkg::SAR_FIRST_EDGE && edge_cnt <= adc_seq_pkg::SAR_LAST_EDGE) begin
        for (int b = 0; b < 12; b++) begin
          if (b == 13 - int'(edge_cnt)) begin
            next_trial[b] = cmp_bit;
            if (b > 0) begin
              next_trial[b-1] = 1'b1;
            end
          end
        end
      end
      if (edge_cnt <= adc_seq_pkg::OUT_LAST_EDGE) begin
        next_dout = word[4'(14 - int'(edge_cnt))];
      end
      if (edge_cnt == adc_seq_pkg::TRACK_EDGE) begin
        next_hold = 1'b0;
      end
      // Control loads at the 12th edge unless this word is bound for the mask.
      if (edge_cnt == adc_seq_pkg::CTRL_LAST_EDGE && state != adc_seq_pkg::S_ARM
          && next_rx[adc_seq_pkg::WRITE_POS]) begin
        next_ctrl = adc_seq_pkg::ctrl_t'(next_rx[10:0]);
        next_wrote = 1'b1;
      end
      // A short frame never reaches here, so it changes no sequencer state.
      if (end_xfer) begin
        next_last_word = word;
        next_active = 1'b0;
        case (state)
          adc_seq_pkg::S_ARM: begin
            next_mask = next_rx;
            next_ptr = next_sel(next_rx, 4'hf);
            next_state = (next_rx == 16'h0000) ? adc_seq_pkg::S_OFF : adc_seq_pkg::S_MASK_RUN;
          end
          default: begin
            if (wrote && !(ctrl.auto_cycle_select && !ctrl.shadow)) begin
              // Any written pair but one-zero ends a running sequence.
              next_ptr = adc_seq_pkg::PTR_RESET;
              case ({ctrl.auto_cycle_select, ctrl.shadow})
                2'b01: next_state = adc_seq_pkg::S_ARM;
                2'b11: next_state = adc_seq_pkg::S_CONSEC;
                default: next_state = adc_seq_pkg::S_OFF;
              endcase
            end else if (state == adc_seq_pkg::S_MASK_RUN) begin
              next_ptr = next_sel(mask, ptr);
            end else if (state == adc_seq_pkg::S_CONSEC) begin
              next_ptr = (ptr == ctrl.channel_addr) ? 4'h0 : ptr + 4'h1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl <= adc_seq_pkg::CTRL_RESET;
      state <= adc_seq_pkg::S_OFF;
      mask <= adc_seq_pkg::MASK_RESET;
      rx <= 16'h0000;
      trial <= 12'h000;
      ptr <= adc_seq_pkg::PTR_RESET;
      conv_ch <= 4'h0;
      edge_cnt <= 5'h00;
      active <= 1'b0;
      wrote <= 1'b0;
      dout <= 1'b0;
      dout_oe_n <= 1'b1;
      track_hold <= 1'b0;
      last_word <= 16'h0000;
    end else begin
      ctrl <= next_ctrl;
      state <= next_state;
      mask <= next_mask;
      rx <= next_rx;
      trial <= next_trial;
      ptr <= next_ptr;
      conv_ch <= next_conv_ch;
      edge_cnt <= next_edge_cnt;
      active <= next_active;
      wrote <= next_wrote;
      dout <= next_dout;
      dout_oe_n <= next_drive_n;
      track_hold <= next_hold;
      last_word <= next_last_word;
    end
  end

  // Analog front end controls; the DAC adds the half-step offset itself.
  assign dac_code = trial;
  assign mux_sel = conv_ch;
  assign span_double = ~ctrl.range;

  // ----------------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------------
  logic ack, next_ack, next_use_test;
  logic [11:0] next_test_level;
  logic [31:0] next_readdata;

  // One wait cycle per access keeps read data registered.
  assign waitrequest = (read | write) & ~ack;

  always_comb begin
    next_ack = (read | write) & ~ack;
    next_readdata = readdata;
    next_test_level = test_level;
    next_use_test = use_test;
    if (read && !ack) begin
      if (address == adc_seq_pkg::OFF_CTRL_VIEW) begin
        next_readdata = {21'h000000, ctrl};
      end else if (address == adc_seq_pkg::OFF_MASK_VIEW) begin
        next_readdata = {16'h0000, mask};
      end else if (address == adc_seq_pkg::OFF_STATUS) begin
        next_readdata = {8'h00, state, ptr, last_word};
      end else if (address == adc_seq_pkg::OFF_TEST_LEVEL) begin
        next_readdata = {20'h00000, test_level};
      end else if (address == adc_seq_pkg::OFF_TEST_CFG) begin
        next_readdata = {31'h00000000, use_test};
      end else begin
        next_readdata = 32'h00000000;
      end
    end
    if (write && ack) begin
      if (address == adc_seq_pkg::OFF_TEST_LEVEL) begin
        next_test_level = writedata[11:0];
      end else if (address == adc_seq_pkg::OFF_TEST_CFG) begin
        next_use_test = writedata[0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack <= 1'b0;
      readdata <= 32'h00000000;
      test_level <= adc_seq_pkg::TEST_LEVEL_RESET;
      use_test <= 1'b0;
    end else begin
      ack <= next_ack;
      readdata <= next_readdata;
      test_level <= next_test_level;
      use_test <= next_use_test;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sar_clocking_a: assert property (@(posedge mclk) disable iff (rst)
    $changed(trial) |-> $past(sclk_fall) || $past(cs_fall))
    else $error("SAR trial moved without a serial edge");
  span_select_a: assert property (@(posedge mclk) disable iff (rst)
    sclk_fall && edge_cnt == 5'h0b && rx[10] && state != adc_seq_pkg::S_ARM
    |=> span_double == !$past(rx[0]))
    else $error("Span output does not follow range bit");
  msb_coding_a: assert property (@(posedge mclk) disable iff (rst)
    sclk_fall && edge_cnt == 5'h03 |=> dout == (trial[11] ^ ctrl.coding))
    else $error("Result MSB coding wrong");
  word_addr_a: assert property (@(posedge mclk) disable iff (rst)
    cs_fall |=> dout == conv_ch[3] && track_hold)
    else $error("Word does not open with channel address");
  fixed_channel_a: assert property (@(posedge mclk) disable iff (rst)
    cs_fall && state == adc_seq_pkg::S_OFF |=> conv_ch == $past(ctrl.channel_addr))
    else $error("Unsequenced channel not from control");
  ctrl_hold_a: assert property (@(posedge mclk) disable iff (rst)
    sclk_fall && edge_cnt == 5'h0b && !rx[10] |=> $stable(ctrl))
    else $error("Control loaded with write bit low");
  mask_start_a: assert property (@(posedge mclk) disable iff (rst)
    end_xfer && state == adc_seq_pkg::S_ARM && next_rx != 16'h0000
    |=> mask[~ptr] && (mask >> (5'h10 - {1'b0, ptr})) == 16'h0000)
    else $error("Sequence did not start at lowest channel");
  mask_point_a: assert property (@(posedge mclk) disable iff (rst)
    state == adc_seq_pkg::S_MASK_RUN |-> mask[~ptr])
    else $error("Pointer on unselected channel");
  consec_wrap_a: assert property (@(posedge mclk) disable iff (rst)
    end_xfer && state == adc_seq_pkg::S_CONSEC && !wrote && ptr == ctrl.channel_addr
    |=> ptr == 4'h0 ##1 state == adc_seq_pkg::S_CONSEC)
    else $error("Consecutive sequence did not wrap");
  seq_exit_a: assert property (@(posedge mclk) disable iff (rst)
    end_xfer && wrote && !ctrl.auto_cycle_select && !ctrl.shadow
    |=> state == adc_seq_pkg::S_OFF)
    else $error("Sequence not ended by write");
  reset_state_a: assert property (@(posedge mclk)
    rst |=> state == adc_seq_pkg::S_OFF && ptr == 4'h0)
    else $error("Reset left sequencer running");
endmodule

//--- tb/serial_host_model.sv
/*
  Behavioural serial host that frames sixteen-bit transfers to the converter.
  Assumes a 50 MHz mclk; the serial clock is made at 160 ns from mclk edges.
*/
`timescale 1ns/10ps

module serial_host_model (
  output logic cs_n,
  output logic sclk,
  output logic din,
  input wire logic mclk,
  input wire logic dout,
  input wire logic dout_oe_n
);
  // ----------------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------------
  // The serial clock stands high between frames, so no stray falls occur.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end

  // One transfer with a chosen number of falls; the host supplies the clock.
  // A released output is seen inverted, so a floating line never matches.
  task automatic frame(input logic [15:0] word_in, input int falls,
                       output logic [15:0] word_out);
    word_out = 16'h0000;
    @(posedge mclk);
    cs_n <= 1'b0;
    repeat (8) @(posedge mclk);
    for (int k = 0; k < falls; k++) begin
      din <= word_in[15-k];
      repeat (4) @(posedge mclk);
      word_out[15-k] = dout_oe_n ? ~dout : dout;
      sclk <= 1'b0;
      repeat (4) @(posedge mclk);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge mclk);
    cs_n <= 1'b1;
    din <= 1'b0;
    repeat (12) @(posedge mclk);
  endtask
endmodule

//--- tb/adc_channel_sequencer_tb_top.sv
/*
  Self-checking bench for the converter sequencer: serial frames and bus reads.
  Assumes the serial host model file and the design package are compiled first.
*/
`timescale 1ns/10ps

module adc_channel_sequencer_tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, din, dout, dout_oe_n, span_double, track_hold, waitrequest;
  logic cmp_in = 1'b0;
  logic [11:0] dac_code;
  logic [3:0] mux_sel;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata, rd;
  logic [11:0] ana_level = 12'h5a3;
  logic [15:0] w;
  int n_fail = 0;
  int n_compared = 0;

  // ----------------------------------------------------------------------
  // Clock, comparator and instances
  // ----------------------------------------------------------------------
  // Free-running system clock.
  always #10 mclk = ~mclk;

  // Ideal comparator; registered so it changes only after a clock edge.
  always @(posedge mclk) cmp_in <= (ana_level >= dac_code);

  adc_channel_sequencer i_adc_channel_sequencer (.mclk(mclk), .rst(rst), .cs_n(cs_n),
    .sclk(sclk), .din(din), .dout(dout), .dout_oe_n(dout_oe_n), .cmp_in(cmp_in),
    .dac_code(dac_code), .mux_sel(mux_sel), .span_double(span_double),
    .track_hold(track_hold), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));

  serial_host_model i_serial_host_model (.cs_n(cs_n), .sclk(sclk), .din(din),
    .mclk(mclk), .dout(dout), .dout_oe_n(dout_oe_n));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Bus read: the request is held until waitrequest is seen low at an edge.
  task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    address <= a;
    read <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask

  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  // Control word: write bit set, power bits kept at normal operation.
  function automatic logic [15:0] ctl(input logic [1:0] pair, input logic [3:0] ch,
                                      input logic rng, input logic cod);
    return {1'b1, pair[1], ch, 2'b11, pair[0], 1'b0, rng, cod, 4'h0};
  endfunction

  // Full transfer whose returned word is compared with channel and code.
  task automatic conv(input logic [15:0] win, input logic [3:0] ch, input logic [11:0] code);
    i_serial_host_model.frame(win, 16, w);
    chk("result word", {16'h0000, w}, {16'h0000, ch, code});
    chk("mux select", {28'h0, mux_sel}, {28'h0, ch});
    chk("track after word", {31'h0, track_hold}, 32'h0);
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------------
  // About 23 frames of 153 cycles are expected; a hang ends far later.
  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    av_rd(adc_seq_pkg::OFF_STATUS, rd);
    chk("state and pointer", {24'h0, rd[23:16]}, 32'h0000_0010);
    av_rd(5'h14, rd);
    chk("unmapped read", rd, 32'h0000_0000);
    av_wr(adc_seq_pkg::OFF_TEST_LEVEL, 32'h0000_0abc);
    av_rd(adc_seq_pkg::OFF_TEST_LEVEL, rd);
    chk("test level", {20'h0, rd[11:0]}, 32'h0000_0abc);
    // Unsequenced conversions and coding.
    conv(ctl(2'b00, 4'h5, 1'b1, 1'b0), 4'h0, 12'h5a3);
    chk("single span", {31'h0, span_double}, 32'h0);
    conv(16'h0000, 4'h5, 12'h5a3);
    i_serial_host_model.frame(ctl(2'b00, 4'h5, 1'b0, 1'b1), 16, w);
    chk("double span", {31'h0, span_double}, 32'h1);
    ana_level <= 12'h800;
    conv(16'h0000, 4'h5, 12'h000);
    ana_level <= 12'h5a3;
    conv(16'h0000, 4'h5, 12'hda3);
    chk("final trial", {20'h0, dac_code}, 32'h0000_05a3);
    // Mask-driven sequence over channels 2, 5 and 15.
    i_serial_host_model.frame(ctl(2'b01, 4'h0, 1'b1, 1'b0), 16, w);
    i_serial_host_model.frame(16'h2401, 16, w);
    av_rd(adc_seq_pkg::OFF_MASK_VIEW, rd);
    chk("mask view", {16'h0, rd[15:0]}, 32'h0000_2401);
    conv(16'h0000, 4'h2, 12'h5a3);
    conv(16'h0000, 4'h5, 12'h5a3);
    conv(16'h0000, 4'hf, 12'h5a3);
    conv(16'h0000, 4'h2, 12'h5a3);
    conv(ctl(2'b10, 4'h9, 1'b1, 1'b0), 4'h5, 12'h5a3);
    conv(16'h0000, 4'hf, 12'h5a3);
    i_serial_host_model.frame(ctl(2'b00, 4'h3, 1'b1, 1'b0), 16, w);
    conv(16'h0000, 4'h3, 12'h5a3);
    // Consecutive sequence from channel 0 up to channel 2.
    i_serial_host_model.frame(ctl(2'b11, 4'h2, 1'b1, 1'b0), 16, w);
    conv(16'h0000, 4'h0, 12'h5a3);
    av_rd(adc_seq_pkg::OFF_STATUS, rd);
    chk("consecutive state", {28'h0, rd[23:20]}, 32'h0000_0008);
    conv(16'h0000, 4'h1, 12'h5a3);
    i_serial_host_model.frame(16'h0000, 10, w);
    chk("hold after short frame", {31'h0, track_hold}, 32'h1);
    conv(16'h0000, 4'h2, 12'h5a3);
    conv(16'h0000, 4'h0, 12'h5a3);
    conv(ctl(2'b10, 4'h7, 1'b1, 1'b0), 4'h1, 12'h5a3);
    conv(16'h0000, 4'h2, 12'h5a3);
    chk("output released", {31'h0, dout_oe_n}, 32'h1);
    give_verdict();
  end
endmodule
